// [common/tsr_link_if.sv]
// Four-wire serial link between the sensor and its master.
// The data-out line is pulled high when the sensor does not drive it.
`timescale 1ns/1ps
interface tsr_link_if;
    logic sclk;
    logic cs_n;
    logic din;
    logic dout;
    logic dout_oe;
    logic dout_line;

    // ==========================================================
    // Resolved level of the shared data-out wire
    assign dout_line = dout_oe ? dout : 1'b1;

    modport sensor (
        input sclk,
        input cs_n,
        input din,
        output dout,
        output dout_oe
    );

    modport master (
        output sclk,
        output cs_n,
        output din,
        input dout_line
    );
endinterface

// [common/tsr_pkg.sv]
// Shared constants and types for the serial temperature sensor and its master.
// Assumes a single 125 MHz core clock on both ends.
package tsr_pkg;

    // ==========================================================
    // Clock and timing
    localparam int unsigned SYS_CLK_HZ = 125_000_000;
    localparam int unsigned CONV_INTERVAL_MS = 1000;
    localparam int unsigned CONV_TIME_US = 800;
    localparam int unsigned INTERVAL_CYC = (SYS_CLK_HZ / 1000) * CONV_INTERVAL_MS;
    localparam int unsigned CONV_CYC = (SYS_CLK_HZ / 1_000_000) * CONV_TIME_US;
    localparam int TIMER_W = 27;
    localparam int CONV_W = 17;
    // Half period of the generated serial clock, in core cycles, less one
    localparam logic [7:0] SCLK_HALF_CYC = 8'h10;

    // ==========================================================
    // Serial word layout
    localparam int WORD_W = 16;
    localparam int VALUE_W = 14;
    localparam int SIGN_BIT = 13;
    localparam int PD_BIT = 13;
    localparam logic [3:0] LAST_BIT = 4'hf;
    localparam logic [1:0] LEAD_ZEROS = 2'h0;
    localparam logic [VALUE_W-1:0] VALUE_RST = 14'h0000;

    // ==========================================================
    // Master register map (Wishbone, byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_PD_BIT = 1;
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_DONE_BIT = 1;

    // ==========================================================
    // State types
    typedef enum logic {
        TSR_CONV_IDLE,
        TSR_CONV_RUN
    } tsr_conv_t;

    typedef enum logic [2:0] {
        TSR_M_IDLE,
        TSR_M_SETUP,
        TSR_M_LOW,
        TSR_M_HIGH,
        TSR_M_HOLD,
        TSR_M_GAP
    } tsr_mstate_t;

endpackage

// [core/tsr_master.sv]
// Serial master for the temperature sensor, controlled over a classic
// Wishbone slave port. Generates the serial clock from core_clk.
// Assumes the sensor answers on the resolved data-out line of the link.
`timescale 1ns/1ps
module tsr_master (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    tsr_link_if.master link
);
    import tsr_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        tsr_mstate_t state;
        logic [7:0] div;
        logic [3:0] bit_cnt;
        logic [WORD_W-1:0] tx;
        logic [WORD_W-1:0] rx;
        logic [WORD_W-1:0] data;
        logic done;
        logic pd;
        logic sclk;
        logic cs_n;
        logic din;
        logic [2:0] dout_sync;
        logic dout_lvl;
        logic ack;
        logic [31:0] rdat;
    } tsr_master_st_t;

    tsr_master_st_t q;
    tsr_master_st_t d;
    logic req;
    logic busy;

    // ==========================================================
    // Next-state logic
    always_comb begin
        d = q;
        req = wb_cyc_i & wb_stb_i & ~q.ack;
        busy = (q.state != TSR_M_IDLE);
        d.ack = req;
        d.dout_sync = {q.dout_sync[1:0], link.dout_line};
        if (q.dout_sync[1] == q.dout_sync[2]) begin
            d.dout_lvl = q.dout_sync[2];
        end

        // Wishbone access; writes to CTRL while busy are ignored
        if (req) begin
            d.rdat = 32'h0000_0000;
            if (wb_we_i) begin
                if (wb_adr_i == REG_CTRL && wb_sel_i[0] && !busy) begin
                    d.pd = wb_dat_i[CTRL_PD_BIT];
                    if (wb_dat_i[CTRL_START_BIT]) begin
                        d.done = 1'b0;
                        // Only the power-down bit may be set in the word
                        d.tx = {2'h0, wb_dat_i[CTRL_PD_BIT], 13'h0000};
                        d.state = TSR_M_SETUP;
                        d.div = SCLK_HALF_CYC;
                        d.cs_n = 1'b0;
                        d.din = 1'b0;
                        d.bit_cnt = 4'h0;
                    end
                end
            end else begin
                unique case (wb_adr_i)
                    REG_CTRL: d.rdat[CTRL_PD_BIT] = q.pd;
                    REG_STATUS: d.rdat = {30'h0, q.done, busy};
                    REG_DATA: d.rdat = {16'h0000, q.data};
                    default: d.rdat = 32'h0000_0000;
                endcase
            end
        end

        // ======================================================
        // Frame sequencer: clock idles high, data changes on falls
        if (busy && q.div != 8'h00) begin
            d.div = q.div - 8'h01;
        end else begin
            unique case (q.state)
                TSR_M_IDLE: begin
                    // A start taken this cycle keeps its select-to-clock setup count
                    if (d.state == TSR_M_IDLE) begin
                        d.div = 8'h00;
                    end
                end
                TSR_M_SETUP, TSR_M_HIGH: begin
                    if (q.state == TSR_M_HIGH) begin
                        d.rx = {q.rx[WORD_W-2:0], q.dout_lvl};
                        d.bit_cnt = q.bit_cnt + 4'h1;
                    end
                    d.div = SCLK_HALF_CYC;
                    if (q.state == TSR_M_HIGH && q.bit_cnt == LAST_BIT) begin
                        d.state = TSR_M_HOLD;
                    end else begin
                        d.state = TSR_M_LOW;
                        d.sclk = 1'b0;
                        d.din = q.tx[WORD_W-1];
                        d.tx = {q.tx[WORD_W-2:0], 1'b0};
                    end
                end
                TSR_M_LOW: begin
                    d.state = TSR_M_HIGH;
                    d.sclk = 1'b1;
                    d.div = SCLK_HALF_CYC;
                end
                TSR_M_HOLD: begin
                    d.state = TSR_M_GAP;
                    d.cs_n = 1'b1;
                    d.din = 1'b0;
                    d.data = q.rx;
                    d.done = 1'b1;
                    d.div = SCLK_HALF_CYC;
                end
                TSR_M_GAP: begin
                    d.state = TSR_M_IDLE;
                end
                default: begin
                    d.state = TSR_M_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            q.state <= TSR_M_IDLE;
            q.div <= 8'h00;
            q.bit_cnt <= 4'h0;
            q.tx <= 16'h0000;
            q.rx <= 16'h0000;
            q.data <= 16'h0000;
            q.done <= 1'b0;
            q.pd <= 1'b0;
            q.sclk <= 1'b1;
            q.cs_n <= 1'b1;
            q.din <= 1'b0;
            q.dout_sync <= 3'h7;
            q.dout_lvl <= 1'b1;
            q.ack <= 1'b0;
            q.rdat <= 32'h0000_0000;
        end else begin
            q <= d;
        end
    end

    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdat;
    assign link.sclk = q.sclk;
    assign link.cs_n = q.cs_n;
    assign link.din = q.din;

endmodule

// [core/tsr_sensor.sv]
// Digital side of the serial temperature sensor: conversion sequencer,
// 14-bit result register and the four-wire serial slave port.
// Assumes the converter result arrives on adc_code in the core clock domain
// and that the link pins are asynchronous to core_clk.
//
// Operation
// - Normal mode converts every second automatically
// - Conversion lasts 800 us then powers down
// - Serial port always live, last result held
// - Shutdown stops timer, no new conversions
// - All-zero control word leaves shutdown, converts
// - Shutdown reads return last completed result
// - Each transaction restarts timer and conversion (here not while shutdown is set)
// - Read aborts conversion, restarts after frame
// - Result register is 14-bit read-only
// - Code equals temperature times 32
// - Serial clock ignored while select high
// - A read is sixteen serial clocks
// - Word is two zeros, fourteen value bits
// - Further sixteen clocks repeat the word
// - Select high releases data output
// - Output bit changes on falling edge
// - Input sampled on rising edge
// - Third control bit selects shutdown
// - Master drives other control bits zero
// - Control word loaded on 16th rise
// - Short frame discards partial control word
// - Master may tie data input low
// - Output word sent MSB first
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module tsr_sensor #(
    parameter int unsigned INTERVAL_CYCLES = tsr_pkg::INTERVAL_CYC,
    parameter int unsigned CONV_CYCLES = tsr_pkg::CONV_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    tsr_link_if.sensor link,
    input wire logic [tsr_pkg::VALUE_W-1:0] adc_code,
    output logic [tsr_pkg::VALUE_W-1:0] temp_value,
    output logic shutdown,
    output logic converting
);
    import tsr_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic [2:0] sclk_sync;
        logic [2:0] cs_sync;
        logic [2:0] din_sync;
        logic sclk_lvl;
        logic cs_lvl;
        logic din_lvl;
        logic [WORD_W-1:0] tx;
        logic [WORD_W-1:0] rx;
        logic [3:0] fall_cnt;
        logic [3:0] rise_cnt;
        logic dout;
        logic dout_oe;
        logic shutdown;
        tsr_conv_t conv;
        logic [TIMER_W-1:0] timer;
        logic [CONV_W-1:0] conv_cnt;
        logic [VALUE_W-1:0] value;
    } tsr_sensor_st_t;

    localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(INTERVAL_CYCLES - 1);
    localparam logic [CONV_W-1:0] CONV_LAST = CONV_W'(CONV_CYCLES - 1);

    tsr_sensor_st_t q;
    tsr_sensor_st_t d;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic [WORD_W-1:0] rx_next;

    // ==========================================================
    // Next-state logic
    always_comb begin
        d = q;
        sclk_rise = 1'b0;
        sclk_fall = 1'b0;
        cs_fall = 1'b0;
        cs_rise = 1'b0;

        // Three-stage synchronisers; a change counts once stages two and
        // three agree, which filters a single-cycle glitch on the pins
        d.sclk_sync = {q.sclk_sync[1:0], link.sclk};
        d.cs_sync = {q.cs_sync[1:0], link.cs_n};
        d.din_sync = {q.din_sync[1:0], link.din};

        if (q.sclk_sync[1] == q.sclk_sync[2] && q.sclk_sync[2] != q.sclk_lvl) begin
            d.sclk_lvl = q.sclk_sync[2];
            sclk_rise = q.sclk_sync[2];
            sclk_fall = ~q.sclk_sync[2];
        end
        if (q.cs_sync[1] == q.cs_sync[2] && q.cs_sync[2] != q.cs_lvl) begin
            d.cs_lvl = q.cs_sync[2];
            cs_rise = q.cs_sync[2];
            cs_fall = ~q.cs_sync[2];
        end
        if (q.din_sync[1] == q.din_sync[2]) begin
            d.din_lvl = q.din_sync[2];
        end

        rx_next = {q.rx[WORD_W-2:0], q.din_lvl};

        // ======================================================
        // Serial port
        if (cs_fall) begin
            // Frame start: snapshot the held result so a late conversion
            // cannot tear the word being shifted
            d.tx = {LEAD_ZEROS, q.value};
            d.fall_cnt = 4'h0;
            d.rise_cnt = 4'h0;
            d.dout_oe = 1'b1;
            d.dout = 1'b0;
            if (q.conv == TSR_CONV_RUN) begin
                d.conv = TSR_CONV_IDLE;
            end
        end else if (cs_rise) begin
            d.dout_oe = 1'b0;
            d.dout = 1'b0;
        end else if (!q.cs_lvl) begin
            // Edges are only honoured while selected
            if (sclk_fall) begin
                d.dout = q.tx[WORD_W-1];
                d.tx = {q.tx[WORD_W-2:0], 1'b0};
                d.fall_cnt = q.fall_cnt + 4'h1;
                if (q.fall_cnt == LAST_BIT) begin
                    d.tx = {LEAD_ZEROS, q.value};
                end
            end
            if (sclk_rise) begin
                d.rx = rx_next;
                d.rise_cnt = q.rise_cnt + 4'h1;
                if (q.rise_cnt == LAST_BIT) begin
                    // Only the power-down bit is acted on; the master keeps
                    // the others at zero
                    d.shutdown = rx_next[PD_BIT];
                end
            end
        end

        // ======================================================
        // Conversion sequencer
        if (cs_rise) begin
            // A finished transaction outside shutdown restarts the sequence; leaving shutdown
            // takes effect here because the word lands mid-frame
            if (!q.shutdown) begin
                d.timer = '0;
                d.conv = TSR_CONV_RUN;
                d.conv_cnt = '0;
            end
        end else if (q.cs_lvl && !cs_fall) begin
            if (q.conv == TSR_CONV_RUN) begin
                d.conv_cnt = q.conv_cnt + CONV_W'(1);
                if (q.conv_cnt == CONV_LAST) begin
                    // Converter powers down once the result is stored
                    d.value = adc_code;
                    d.conv = TSR_CONV_IDLE;
                end
            end
            if (q.shutdown) begin
                // Oscillator stopped: the interval timer holds at zero
                d.timer = '0;
            end else if (q.timer == TIMER_LAST) begin
                d.timer = '0;
                d.conv = TSR_CONV_RUN;
                d.conv_cnt = '0;
            end else begin
                d.timer = q.timer + TIMER_W'(1);
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            q.sclk_sync <= 3'h7;
            q.cs_sync <= 3'h7;
            q.din_sync <= 3'h0;
            q.sclk_lvl <= 1'b1;
            q.cs_lvl <= 1'b1;
            q.din_lvl <= 1'b0;
            q.tx <= 16'h0000;
            q.rx <= 16'h0000;
            q.fall_cnt <= 4'h0;
            q.rise_cnt <= 4'h0;
            q.dout <= 1'b0;
            q.dout_oe <= 1'b0;
            q.shutdown <= 1'b0;
            // A first conversion starts straight out of reset
            q.conv <= TSR_CONV_RUN;
            q.timer <= '0;
            q.conv_cnt <= '0;
            q.value <= VALUE_RST;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs
    // The result register stays readable in every mode
    assign temp_value = q.value;
    assign shutdown = q.shutdown;
    assign converting = (q.conv == TSR_CONV_RUN);
    assign link.dout = q.dout;
    assign link.dout_oe = q.dout_oe;

endmodule

// [verif/temp_sensor_serial_readout_tb.sv]
// Bench: master and sensor joined over one link, plus a second sensor whose
// link the bench drives itself. Assumes package, interface and design compiled first.
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
    $display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); end end
module temp_sensor_serial_readout_tb;
    import tsr_pkg::*;
    // Shortened counts keep the run short
    localparam int unsigned INTV = 2000;
    localparam int unsigned CONV = 200;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'hf;
    logic [31:0] wb_dat_w = 32'h0;
    logic [31:0] wb_dat_r;
    logic wb_ack;
    logic [VALUE_W-1:0] adc_a = 14'h0320;
    logic [VALUE_W-1:0] adc_b = 14'h12c0;
    logic [VALUE_W-1:0] temp_a;
    logic shut_a, shut_b, conv_a;
    int err_total = 0;
    int total_checks = 0;
    tsr_link_if link_a();
    tsr_link_if link_b();
    initial begin
        link_b.sclk = 1'b1;
        link_b.cs_n = 1'b1;
        link_b.din = 1'b0;
    end
    tsr_master tsr_master_inst (.core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
        .wb_ack_o(wb_ack), .link(link_a.master));
    tsr_sensor #(.INTERVAL_CYCLES(INTV), .CONV_CYCLES(CONV)) tsr_sensor_inst (.core_clk(core_clk),
        .reset(reset), .link(link_a.sensor), .adc_code(adc_a), .temp_value(temp_a), .shutdown(shut_a),
        .converting(conv_a));
    tsr_sensor #(.INTERVAL_CYCLES(INTV), .CONV_CYCLES(CONV)) tsr_sensor_inst2 (.core_clk(core_clk),
        .reset(reset), .link(link_b.sensor), .adc_code(adc_b), .temp_value(), .shutdown(shut_b),
        .converting());
    tsr_props tsr_props_inst (.core_clk(core_clk), .reset(reset), .sclk(link_a.sclk), .cs_n(link_a.cs_n),
        .din(link_a.din), .dout(link_a.dout), .dout_oe(link_a.dout_oe), .dout_line(link_a.dout_line));
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    // ==========================================================
    // Bus and link tasks
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Ack is sampled on the rising edge; the request is released at that same edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge core_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_w <= dat;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            $display("[FAIL] %0t no bus answer", $time);
        end
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask
    task automatic frm(input logic pd, output logic [15:0] w);
        logic [31:0] c, q;
        int n;
        c = 32'h0;
        c[CTRL_START_BIT] = 1'b1;
        c[CTRL_PD_BIT] = pd;
        wb(1'b1, REG_CTRL, c, q);
        n = 0;
        // Wait past the trailing gap too: a start issued while busy is dropped
        do begin
            wb(1'b0, REG_STATUS, 32'h0, q);
            n++;
        end while ((q[STATUS_DONE_BIT] !== 1'b1 || q[STATUS_BUSY_BIT] !== 1'b0) && n < 400);
        `CHK(n < 400, 1'b1)
        wb(1'b0, REG_DATA, 32'h0, q);
        w = q[15:0];
    endtask
    // Half period of 8 core cycles: under half the 17-cycle half period of the master's link clock
    task automatic bb(input int n, input logic [15:0] w, output logic [31:0] rx, output logic sd);
        rx = 32'h0;
        @(posedge core_clk);
        link_b.cs_n <= 1'b0;
        repeat (8) @(posedge core_clk);
        for (int i = 0; i < n; i++) begin
            link_b.sclk <= 1'b0;
            link_b.din <= w[15 - (i % 16)];
            repeat (8) @(posedge core_clk);
            link_b.sclk <= 1'b1;
            repeat (8) @(posedge core_clk);
            rx = {rx[30:0], link_b.dout_line};
        end
        link_b.din <= 1'b0;
        repeat (8) @(posedge core_clk);
        sd = shut_b;
        link_b.cs_n <= 1'b1;
        repeat (10) @(posedge core_clk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        logic [31:0] q;
        `CHK(temp_a, 14'h0000)
        `CHK(shut_a, 1'b0)
        `CHK(conv_a, 1'b1)
        wb(1'b0, 8'h0c, 32'h0, q);
        `CHK(q, 32'h0)
        wb(1'b1, 8'h0c, 32'h2, q);
        wb(1'b0, REG_CTRL, 32'h0, q);
        `CHK(q[CTRL_PD_BIT], 1'b0)
        repeat (CONV + 20) @(posedge core_clk);
        `CHK(temp_a, 14'h0320)
        `CHK(conv_a, 1'b0)
    endtask
    task automatic t_read_abort_timer;
        logic [15:0] w;
        frm(1'b0, w);
        `CHK(w, 16'h0320)
        adc_a <= 14'h3b00;
        repeat (6) @(posedge core_clk);
        `CHK(conv_a, 1'b1)
        repeat (CONV + 20) @(posedge core_clk);
        `CHK(temp_a, 14'h3b00)
        adc_a <= 14'h0140;
        frm(1'b0, w);
        `CHK(w, 16'h3b00)
        frm(1'b0, w);
        `CHK(w, 16'h3b00)
        `CHK(temp_a, 14'h3b00)
        repeat (CONV + 20) @(posedge core_clk);
        `CHK(temp_a, 14'h0140)
        adc_a <= 14'h3fff;
        repeat (INTV / 2) @(posedge core_clk);
        `CHK(temp_a, 14'h0140)
        repeat (INTV / 2 + CONV + 40) @(posedge core_clk);
        `CHK(temp_a, 14'h3fff)
    endtask
    task automatic t_shutdown;
        logic [15:0] w;
        frm(1'b1, w);
        `CHK(w, 16'h3fff)
        `CHK(shut_a, 1'b1)
        adc_a <= 14'h0c80;
        repeat (INTV + CONV + 40) @(posedge core_clk);
        `CHK(temp_a, 14'h3fff)
        `CHK(conv_a, 1'b0)
        frm(1'b1, w);
        `CHK(w, 16'h3fff)
        frm(1'b0, w);
        `CHK(shut_a, 1'b0)
        repeat (CONV + 20) @(posedge core_clk);
        `CHK(temp_a, 14'h0c80)
    endtask
    task automatic t_link_faults;
        logic [31:0] rx;
        logic sd;
        bb(32, 16'h0000, rx, sd);
        `CHK(rx, 32'h12c012c0)
        `CHK(link_b.dout_oe, 1'b0)
        `CHK(link_b.dout_line, 1'b1)
        for (int i = 0; i < 6; i++) begin
            link_b.din <= 1'b1;
            link_b.sclk <= ~link_b.sclk;
            repeat (8) @(posedge core_clk);
        end
        `CHK(link_b.dout_oe, 1'b0)
        bb(8, 16'h2000, rx, sd);
        `CHK(shut_b, 1'b0)
        bb(16, 16'h2000, rx, sd);
        `CHK(rx[15:0], 16'h12c0)
        `CHK(sd, 1'b1)
    endtask
    initial begin
        repeat (12) @(posedge core_clk);
        reset <= 1'b0;
        repeat (6) @(posedge core_clk);
        t_reset();
        t_read_abort_timer();
        t_shutdown();
        t_link_faults();
        end_of_test();
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        err_total++;
        $display("[FAIL] %0t run did not finish", $time);
        end_of_test();
    end
endmodule

// [verif/tsr_props.sv]
// Concurrent checks on the serial link between the master and the sensor.
// Assumes every link signal is watched in the core_clk domain, synchronous reset.
`timescale 1ns/1ps
module tsr_props (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic dout_line
);
    // ==========================================================
    // Rising serial clock edges seen so far in the current frame
    logic sclk_q;
    logic [5:0] rise_q;
    always_ff @(posedge core_clk) begin
        sclk_q <= reset ? 1'b1 : sclk;
        if (reset || cs_n) begin
            rise_q <= 6'h00;
        end else if (sclk && !sclk_q) begin
            rise_q <= rise_q + 6'h01;
        end
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    // ==========================================================
    // Sensor side
    AST_OE_ON: assert property ($fell(cs_n) |-> ##[1:8] dout_oe)
        else $error("data out not driven after select");
    AST_OE_FRAME: assert property ($rose(sclk) && !cs_n |-> dout_oe)
        else $error("data out released inside a frame");
    AST_OE_OFF: assert property ($rose(cs_n) |-> ##[1:8] !dout_oe)
        else $error("data out still driven after deselect");
    AST_QUIET: assert property (cs_n [*8] |-> !dout_oe)
        else $error("data out driven while deselected");
    AST_LEAD: assert property ($rose(sclk) && !cs_n && rise_q[3:0] < 4'h2 |-> !dout_line)
        else $error("leading bit of word not zero");
    AST_OUT_STABLE: assert property (!cs_n && sclk && $past(sclk) && rise_q != 6'h00 |-> $stable(dout))
        else $error("data out moved while serial clock high");
    // ==========================================================
    // Master side
    AST_SETUP: assert property ($fell(cs_n) |-> sclk [*8])
        else $error("serial clock left idle too soon after select");
    AST_COUNT: assert property ($rose(cs_n) |-> rise_q == 6'h10)
        else $error("frame not sixteen clocks");
    AST_IDLE_SCLK: assert property (cs_n |-> sclk)
        else $error("serial clock toggles while deselected");
    AST_DIN_ZERO: assert property ($rose(sclk) && !cs_n && rise_q[3:0] != 4'h2 |-> !din)
        else $error("control bit other than power-down not zero");
    AST_DIN_HOLD: assert property ($rose(sclk) |=> $stable(din))
        else $error("data in moved right after rising clock");
endmodule
